// *** hdl/ascr_defs.svh ***
`ifndef ASCR_DEFS_SVH
`define ASCR_DEFS_SVH

// Register byte offsets
`define ASCR_OFF_CTRL 12'h000
`define ASCR_OFF_STATUS 12'h004
`define ASCR_OFF_MASK 12'h008
`define ASCR_OFF_RES_LO 12'h00C
`define ASCR_OFF_RES_HI 12'h010

// Control register fields
`define ASCR_CTRL_ENABLE 0
`define ASCR_CTRL_START 1
`define ASCR_CTRL_DIFF 2
`define ASCR_CTRL_LEFT 3
`define ASCR_CTRL_FREE 4
`define ASCR_CTRL_W 5

// Status and mask fields
`define ASCR_ST_DONE 0
`define ASCR_ST_SLEEPCONV 1
`define ASCR_ST_W 2

// Reset values
`define ASCR_CTRL_RST 5'h00
`define ASCR_ST_RST 2'h0
`define ASCR_RES_RST 10'h000

// Timing in converter clock cycles
`define ASCR_PRESCALE 2
`define ASCR_CONV_CYCLES 13
`define ASCR_FIRST_CONV_CYCLES 25

// Result code limits
`define ASCR_SE_MAX 12'sh3FF
`define ASCR_DIFF_MAX 12'sh1FF
`define ASCR_DIFF_MIN -12'sh200

`endif

// *** hdl/ascr_pkg.sv ***
package ascr_pkg;
  typedef enum logic [1:0] {
    ASCR_ST_IDLE = 2'b00,
    ASCR_ST_CONV = 2'b01
  } ascr_state_e;

  typedef enum logic [2:0] {
    ASCR_SLP_IDLE = 3'b000,
    ASCR_SLP_NOISE = 3'b001,
    ASCR_SLP_POWERDOWN = 3'b010,
    ASCR_SLP_POWERSAVE = 3'b011,
    ASCR_SLP_STANDBY = 3'b110,
    ASCR_SLP_EXTSTANDBY = 3'b111
  } ascr_sleep_e;
endpackage

// *** hdl/ascr_sleep_conv.sv ***
// Contract
// - Entering noise-reduction or idle sleep with the converter armed starts one conversion once the CPU halts.
// - With no other wake source the completion interrupt wakes the CPU for its service routine.
// - If another interrupt wakes the CPU first, the completion request is still posted when conversion ends.
// - Other sleep modes leave the converter enable untouched.
// - The result sits in the low and high result bytes, valid once the done flag is high.
// - Single-ended results are unsigned codes from 0x000 to 0x3FF.
// - Differential results are ten-bit two's complement codes from 0x200 to 0x1FF.
// - In differential mode bit nine is the sign, one for a negative difference.
// - Differential codes clamp at 0x1FF and 0x200, with one step below zero reading 0x3FF.
// - Left alignment puts the upper eight result bits in the high byte, otherwise bits nine and eight go there.
// - Changing left alignment alters the presented result at once, whatever the converter is doing.
`timescale 1ns/100ps
`default_nettype none
`include "ascr_defs.svh"

module ascr_sleep_conv
  import ascr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_halted,
  input wire logic [2:0] sleep_mode,
  input wire logic signed [11:0] analog_code,
  output logic converter_enable,
  output logic conv_busy,
  output logic irq
);

  localparam int CONV_LEN = `ASCR_CONV_CYCLES * `ASCR_PRESCALE;
  localparam int FIRST_LEN = `ASCR_FIRST_CONV_CYCLES * `ASCR_PRESCALE;

  logic [`ASCR_CTRL_W-1:0] ctrl_reg;
  logic [`ASCR_ST_W-1:0] status_reg;
  logic [`ASCR_ST_W-1:0] mask_reg;
  logic [9:0] result_reg;
  logic [9:0] result_next;
  logic [31:0] prdata_reg;
  logic [31:0] rdata_next;
  logic [5:0] count_reg;
  logic first_pending_reg;
  logic halted_q_reg;
  logic sleep_start_reg;
  ascr_state_e state_reg;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic conv_end;
  logic sw_start;
  logic halt_rise;
  logic sleep_arm;
  logic [7:0] result_low_byte;
  logic [7:0] result_high_byte;

  // Access phase completes in one cycle, so pready is constant high
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = (paddr == `ASCR_OFF_CTRL) || (paddr == `ASCR_OFF_STATUS) ||
                  (paddr == `ASCR_OFF_MASK) || (paddr == `ASCR_OFF_RES_LO) ||
                  (paddr == `ASCR_OFF_RES_HI);
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;

  // Control outputs straight from state
  assign converter_enable = ctrl_reg[`ASCR_CTRL_ENABLE];
  assign conv_busy = (state_reg == ASCR_ST_CONV);
  assign irq = |(status_reg & mask_reg);

  // Edge on the halt input marks the moment the core stops executing
  assign halt_rise = cpu_halted && !halted_q_reg;
  // Sleep start needs enable, idle converter and single-shot mode
  assign sleep_arm = ctrl_reg[`ASCR_CTRL_ENABLE] && (state_reg == ASCR_ST_IDLE) &&
                     !ctrl_reg[`ASCR_CTRL_FREE] &&
                     ((sleep_mode == ASCR_SLP_IDLE) || (sleep_mode == ASCR_SLP_NOISE));
  assign sw_start = wr_en && (paddr == `ASCR_OFF_CTRL) && pwdata[`ASCR_CTRL_START] &&
                    pwdata[`ASCR_CTRL_ENABLE];
  assign conv_end = (state_reg == ASCR_ST_CONV) && (count_reg == 6'h01);

  // Halt input history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_q_reg <= 1'b0;
    end else begin
      halted_q_reg <= cpu_halted;
    end
  end

  // Control register; hardware never clears the enable on sleep entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `ASCR_CTRL_RST;
    end else if (wr_en && (paddr == `ASCR_OFF_CTRL)) begin
      ctrl_reg <= pwdata[`ASCR_CTRL_W-1:0] & ~(5'h01 << `ASCR_CTRL_START);
    end
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= `ASCR_ST_RST;
    end else if (wr_en && (paddr == `ASCR_OFF_MASK)) begin
      mask_reg <= pwdata[`ASCR_ST_W-1:0];
    end
  end

  // Extended first conversion after each enable, since the analog front end needs settling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_pending_reg <= 1'b1;
    end else if (!ctrl_reg[`ASCR_CTRL_ENABLE]) begin
      first_pending_reg <= 1'b1;
    end else if (state_reg == ASCR_ST_CONV) begin
      first_pending_reg <= 1'b0;
    end
  end

  // Conversion sequencer; clearing enable aborts a running conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ASCR_ST_IDLE;
      count_reg <= 6'h00;
      sleep_start_reg <= 1'b0;
    end else begin
      case (state_reg)
        ASCR_ST_IDLE: begin
          if (halt_rise && sleep_arm) begin
            state_reg <= ASCR_ST_CONV;
            count_reg <= first_pending_reg ? 6'(FIRST_LEN) : 6'(CONV_LEN);
            sleep_start_reg <= 1'b1;
          end else if (sw_start && (state_reg == ASCR_ST_IDLE)) begin
            state_reg <= ASCR_ST_CONV;
            count_reg <= first_pending_reg ? 6'(FIRST_LEN) : 6'(CONV_LEN);
            sleep_start_reg <= 1'b0;
          end
        end
        ASCR_ST_CONV: begin
          if (!ctrl_reg[`ASCR_CTRL_ENABLE]) begin
            state_reg <= ASCR_ST_IDLE;
            count_reg <= 6'h00;
          end else if (conv_end) begin
            // Free running restarts at once with a normal length
            if (ctrl_reg[`ASCR_CTRL_FREE]) begin
              count_reg <= 6'(CONV_LEN);
            end else begin
              state_reg <= ASCR_ST_IDLE;
              count_reg <= 6'h00;
            end
            sleep_start_reg <= 1'b0;
          end else begin
            count_reg <= count_reg - 6'h01;
          end
        end
        default: begin
          state_reg <= ASCR_ST_IDLE;
          count_reg <= 6'h00;
        end
      endcase
    end
  end

  // Clamp the quantiser output into the code range of the input kind
  always_comb begin
    result_next = result_reg;
    if (ctrl_reg[`ASCR_CTRL_DIFF]) begin
      if (analog_code > `ASCR_DIFF_MAX) begin
        result_next = 10'h1FF;
      end else if (analog_code < `ASCR_DIFF_MIN) begin
        result_next = 10'h200;
      end else begin
        result_next = analog_code[9:0];
      end
    end else begin
      if (analog_code < 12'sh000) begin
        result_next = 10'h000;
      end else if (analog_code > `ASCR_SE_MAX) begin
        result_next = 10'h3FF;
      end else begin
        result_next = analog_code[9:0];
      end
    end
  end

  // Result capture happens in the same cycle the done flag sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= `ASCR_RES_RST;
    end else if (conv_end && ctrl_reg[`ASCR_CTRL_ENABLE]) begin
      result_reg <= result_next;
    end
  end

  // Sticky status; a hardware set beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= `ASCR_ST_RST;
    end else begin
      if (wr_en && (paddr == `ASCR_OFF_STATUS)) begin
        status_reg <= status_reg & ~pwdata[`ASCR_ST_W-1:0];
      end
      if (conv_end && ctrl_reg[`ASCR_CTRL_ENABLE]) begin
        status_reg[`ASCR_ST_DONE] <= 1'b1;
        // Only a sleep start sets this bit, so a same-cycle clear still lands otherwise
        if (sleep_start_reg) begin
          status_reg[`ASCR_ST_SLEEPCONV] <= 1'b1;
        end
      end
    end
  end

  // Presentation follows the alignment bit live, not the capture time
  // alignment select
  assign result_high_byte = ctrl_reg[`ASCR_CTRL_LEFT] ? result_reg[9:2] : {6'h00, result_reg[9:8]};
  assign result_low_byte = ctrl_reg[`ASCR_CTRL_LEFT] ? {result_reg[1:0], 6'h00} : result_reg[7:0];

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      `ASCR_OFF_CTRL: rdata_next = {27'h000_0000, ctrl_reg[4:2], conv_busy, ctrl_reg[0]};
      `ASCR_OFF_STATUS: rdata_next = {30'h0000_0000, status_reg};
      `ASCR_OFF_MASK: rdata_next = {30'h0000_0000, mask_reg};
      `ASCR_OFF_RES_LO: rdata_next = {24'h00_0000, result_low_byte};
      `ASCR_OFF_RES_HI: rdata_next = {24'h00_0000, result_high_byte};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data is latched in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_reg <= rdata_next;
    end
  end

  // Checks
  sequence s_armed_halt;
    halt_rise && sleep_arm;
  endsequence

  sequence s_conv_run;
    (state_reg == ASCR_ST_CONV) [*8];
  endsequence

  property p_sleep_start;
    @(posedge pclk) disable iff (!presetn)
    s_armed_halt |=> s_conv_run;
  endproperty
  a_sleep_start: assert property (p_sleep_start) else $error("sleep conversion did not start");

  property p_wake_irq;
    @(posedge pclk) disable iff (!presetn)
    (conv_end && converter_enable && mask_reg[`ASCR_ST_DONE]) |=> irq;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("completion did not raise irq");

  property p_req_posted;
    @(posedge pclk) disable iff (!presetn)
    (conv_end && converter_enable) |=> status_reg[`ASCR_ST_DONE];
  endproperty
  a_req_posted: assert property (p_req_posted) else $error("done flag not set");

  property p_enable_kept;
    @(posedge pclk) disable iff (!presetn)
    (cpu_halted && !(wr_en && (paddr == `ASCR_OFF_CTRL))) |=> $stable(converter_enable);
  endproperty
  a_enable_kept: assert property (p_enable_kept) else $error("enable changed without write");

  property p_result_pair;
    @(posedge pclk) disable iff (!presetn)
    $rose(status_reg[`ASCR_ST_DONE]) |-> (result_reg == $past(result_next));
  endproperty
  a_result_pair: assert property (p_result_pair) else $error("result not updated with flag");

  property p_se_top;
    @(posedge pclk) disable iff (!presetn)
    (conv_end && converter_enable && !ctrl_reg[`ASCR_CTRL_DIFF] && analog_code > 12'sh3FF)
      |=> (result_reg == 10'h3FF);
  endproperty
  a_se_top: assert property (p_se_top) else $error("single-ended not saturated");

  property p_diff_clamp;
    @(posedge pclk) disable iff (!presetn)
    (conv_end && converter_enable && ctrl_reg[`ASCR_CTRL_DIFF] && analog_code < -12'sh200)
      |=> (result_reg == 10'h200);
  endproperty
  a_diff_clamp: assert property (p_diff_clamp) else $error("negative clamp wrong");

  property p_sign;
    @(posedge pclk) disable iff (!presetn)
    (conv_end && converter_enable && ctrl_reg[`ASCR_CTRL_DIFF])
      |=> (result_reg[9] == $past(analog_code[11]));
  endproperty
  a_sign: assert property (p_sign) else $error("sign bit wrong");

  property p_align;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_reg[`ASCR_CTRL_LEFT] && rd_setup && (paddr == `ASCR_OFF_RES_HI))
      |=> (prdata_reg[7:0] == $past(result_reg[9:2]));
  endproperty
  a_align: assert property (p_align) else $error("alignment not applied");

endmodule

`default_nettype wire

// *** verification/ascr_cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// Stand-in for the CPU core: halts on a sleep request, wakes on irq or another source
module ascr_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sleep_req,
  input wire logic [2:0] req_mode,
  input wire logic other_wake,
  input wire logic irq,
  output logic cpu_halted,
  output logic [2:0] sleep_mode,
  output logic [7:0] irq_wakes
);
  // Sleep entry and wakeup; the bench arms or disarms the converter before asking
  // software prepares converter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_halted <= 1'b0;
      sleep_mode <= 3'h0;
      irq_wakes <= 8'h00;
    end else if (!cpu_halted && sleep_req) begin
      cpu_halted <= 1'b1;
      sleep_mode <= req_mode;
    end else if (cpu_halted && (irq || other_wake)) begin
      // Stays awake until the next request, as a real core would
      cpu_halted <= 1'b0;
      irq_wakes <= irq_wakes + {7'h00, irq};
    end
  end
endmodule

`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ascr_defs.svh"

`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("BAD t=%0t got %h exp %h", $time, (got), (exp)); \
    end \
  end

module tb;
  import ascr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sleep_req, other_wake, serr;
  logic pready, pslverr, cpu_halted, converter_enable, conv_busy, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] sleep_mode, req_mode;
  logic signed [11:0] analog_code;
  logic [7:0] irq_wakes;
  int bad_count = 0;
  int n_tests = 0;
  int len;

  ascr_sleep_conv DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_halted(cpu_halted), .sleep_mode(sleep_mode), .analog_code(analog_code),
    .converter_enable(converter_enable), .conv_busy(conv_busy), .irq(irq));

  ascr_cpu_model cpu (.pclk(pclk), .presetn(presetn), .sleep_req(sleep_req), .req_mode(req_mode),
    .other_wake(other_wake), .irq(irq), .cpu_halted(cpu_halted), .sleep_mode(sleep_mode),
    .irq_wakes(irq_wakes));

  // 50 ns clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // One APB transfer, request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Busy length in cycles; sampled on the falling edge where all is settled
  task automatic busy_len(output int l);
    int w;
    w = 0;
    l = 0;
    // Always move to a falling edge first, so the count never starts on a launch edge
    do begin
      @(negedge pclk);
      w++;
    end while (conv_busy !== 1'b1 && w < 200);
    while (conv_busy === 1'b1 && l < 200) begin
      @(negedge pclk);
      l++;
    end
  endtask

  task automatic go_sleep(input logic [2:0] m);
    @(posedge pclk);
    sleep_req <= 1'b1;
    req_mode <= m;
    @(posedge pclk);
    sleep_req <= 1'b0;
  endtask

  task automatic poke_wake();
    @(posedge pclk);
    other_wake <= 1'b1;
    @(posedge pclk);
    other_wake <= 1'b0;
    @(negedge pclk);
  endtask

  // Clamped ten-bit code expected for a quantiser value
  function automatic logic [9:0] exp_code(input logic dif, input int v);
    int lo;
    int hi;
    lo = dif ? -512 : 0;
    hi = dif ? 511 : 1023;
    if (v < lo) v = lo;
    if (v > hi) v = hi;
    return v[9:0];
  endfunction

  // Reset values of every register and an unmapped word
  task automatic t_reset();
    logic [11:0] offs [5] = '{`ASCR_OFF_CTRL, `ASCR_OFF_STATUS, `ASCR_OFF_MASK, `ASCR_OFF_RES_LO, `ASCR_OFF_RES_HI};
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      `CHK(serr, 1'b0)
      `CHK(pready, 1'b1)
    end
    // A write with byte lane zero disabled is dropped
    pstrb <= 4'h0;
    apb(1'b1, `ASCR_OFF_MASK, 32'h0000_0003);
    pstrb <= 4'hF;
    apb(1'b0, `ASCR_OFF_MASK, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, 12'h014, 32'h0000_0000);
    `CHK(serr, 1'b1)
  endtask

  // Noise-reduction sleep starts a first conversion and irq wakes the core
  task automatic t_sleep();
    analog_code <= 12'sh155;
    apb(1'b1, `ASCR_OFF_MASK, 32'h0000_0003);
    apb(1'b1, `ASCR_OFF_CTRL, 32'h0000_0001);
    go_sleep(ASCR_SLP_NOISE);
    busy_len(len);
    `CHK(len, 50)
    `CHK(irq, 1'b1)
    @(negedge pclk);
    `CHK(cpu_halted, 1'b0)
    `CHK(irq_wakes, 8'h01)
    apb(1'b0, `ASCR_OFF_STATUS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0003)
    apb(1'b0, `ASCR_OFF_RES_LO, 32'h0000_0000);
    `CHK(rd, 32'h0000_0055)
    apb(1'b0, `ASCR_OFF_RES_HI, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    apb(1'b1, `ASCR_OFF_STATUS, 32'h0000_0003);
  endtask

  // Idle sleep cut short by another source; completion still posts irq
  task automatic t_other_wake();
    go_sleep(ASCR_SLP_IDLE);
    poke_wake();
    `CHK(cpu_halted, 1'b0)
    `CHK(conv_busy, 1'b1)
    busy_len(len);
    `CHK(irq, 1'b1)
    `CHK(irq_wakes, 8'h01)
    apb(1'b1, `ASCR_OFF_STATUS, 32'h0000_0003);
  endtask

  // Deeper sleeps leave the converter on and idle
  task automatic t_other_modes();
    logic [2:0] modes [4] = '{ASCR_SLP_POWERDOWN, ASCR_SLP_POWERSAVE, ASCR_SLP_STANDBY, ASCR_SLP_EXTSTANDBY};
    foreach (modes[i]) begin
      go_sleep(modes[i]);
      repeat (30) @(negedge pclk);
      `CHK(converter_enable, 1'b1)
      `CHK(conv_busy, 1'b0)
      poke_wake();
    end
    apb(1'b0, `ASCR_OFF_STATUS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    // toggle enable for an extended conversion
    apb(1'b1, `ASCR_OFF_CTRL, 32'h0000_0000);
    apb(1'b1, `ASCR_OFF_CTRL, 32'h0000_0001);
    apb(1'b1, `ASCR_OFF_CTRL, 32'h0000_0003);
    busy_len(len);
    `CHK(len, 50)
    apb(1'b1, `ASCR_OFF_STATUS, 32'h0000_0003);
  endtask

  // Codes, clamps and both alignments, mask alternating
  task automatic t_format();
    logic dif [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    int val [7] = '{-5, 1500, 341, 600, -600, -1, -400};
    logic [9:0] r;
    for (int i = 0; i < 7; i++) begin
      r = exp_code(dif[i], val[i]);
      analog_code <= 12'(val[i]);
      apb(1'b1, `ASCR_OFF_MASK, 32'(i & 1));
      apb(1'b1, `ASCR_OFF_CTRL, {28'h000_0000, 1'b0, dif[i], 2'b11});
      busy_len(len);
      `CHK(len, 26)
      `CHK(irq, i[0])
      apb(1'b0, `ASCR_OFF_RES_LO, 32'h0000_0000);
      `CHK(rd, {24'h00_0000, r[7:0]})
      apb(1'b0, `ASCR_OFF_RES_HI, 32'h0000_0000);
      `CHK(rd, {30'h0000_0000, r[9:8]})
      if (dif[i]) `CHK(rd[1], (val[i] < 0))
      apb(1'b1, `ASCR_OFF_CTRL, {28'h000_0000, 1'b1, dif[i], 2'b01});
      apb(1'b0, `ASCR_OFF_RES_LO, 32'h0000_0000);
      `CHK(rd, {24'h00_0000, r[1:0], 6'h00})
      apb(1'b0, `ASCR_OFF_RES_HI, 32'h0000_0000);
      `CHK(rd, {24'h00_0000, r[9:2]})
      apb(1'b1, `ASCR_OFF_STATUS, 32'h0000_0003);
      @(negedge pclk);
      `CHK(irq, 1'b0)
    end
  endtask

  // Residue from one channel against itself, removed from a later result
  task automatic t_offset();
    logic [9:0] zero_res;
    logic [9:0] corr;
    analog_code <= 12'sh003;
    apb(1'b1, `ASCR_OFF_CTRL, 32'h0000_0007);
    busy_len(len);
    apb(1'b0, `ASCR_OFF_RES_HI, 32'h0000_0000);
    zero_res[9:8] = rd[1:0];
    apb(1'b0, `ASCR_OFF_RES_LO, 32'h0000_0000);
    zero_res[7:0] = rd[7:0];
    `CHK(zero_res, 10'h003)
    analog_code <= -12'sh08D;
    apb(1'b1, `ASCR_OFF_CTRL, 32'h0000_0007);
    busy_len(len);
    apb(1'b0, `ASCR_OFF_RES_HI, 32'h0000_0000);
    corr[9:8] = rd[1:0];
    apb(1'b0, `ASCR_OFF_RES_LO, 32'h0000_0000);
    corr[7:0] = rd[7:0];
    corr = corr - zero_res;
    `CHK(corr, 10'h370)
    apb(1'b1, `ASCR_OFF_STATUS, 32'h0000_0003);
  endtask

  // Free running converts back to back until enable is cleared
  task automatic t_free();
    analog_code <= 12'sh0AA;
    apb(1'b1, `ASCR_OFF_CTRL, 32'h0000_0013);
    repeat (60) @(negedge pclk);
    `CHK(conv_busy, 1'b1)
    apb(1'b0, `ASCR_OFF_STATUS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    apb(1'b0, `ASCR_OFF_RES_LO, 32'h0000_0000);
    `CHK(rd, 32'h0000_00AA)
    apb(1'b0, `ASCR_OFF_CTRL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0013)
    apb(1'b1, `ASCR_OFF_CTRL, 32'h0000_0000);
    repeat (2) @(negedge pclk);
    `CHK(conv_busy, 1'b0)
    `CHK(converter_enable, 1'b0)
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    sleep_req = 1'b0;
    req_mode = 3'h0;
    other_wake = 1'b0;
    analog_code = 12'sh000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sleep();
    t_other_wake();
    t_other_modes();
    t_format();
    t_offset();
    t_free();
    complete_run();
  end

  // Watchdog, well beyond the thousand or so cycles the run needs
  initial begin
    repeat (8000) @(posedge pclk);
    bad_count++;
    complete_run();
  end
endmodule

`default_nettype wire
